// *** hdl/key_scanner.v ***
`include "lcd_sysctl_map.vh"

module key_scanner #(
   parameter UNIT_CYCLES = `SCAN_UNIT_MS * `CLK_KHZ,
   parameter LONG_CYCLES = `LONG_PRESS_MS * `CLK_KHZ
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // control
   input wire run,
   input wire scan_en,
   input wire [3:0] scan_period,
   // matrix pins
   input wire [4:0] key_sense_in,
   output reg [3:0] key_strobe_out,
   // results
   output reg [7:0] key_code,
   output reg press_evt,
   output reg long_evt,
   output reg sense_any
);
   reg [4:0] sense_s1_reg;
   reg [4:0] sense_s2_reg;
   reg [25:0] unit_cnt_reg;
   reg [3:0] step_cnt_reg;
   reg [1:0] col_reg;
   reg [4:0] last_mem [0:3];
   reg [4:0] stable_mem [0:3];
   reg held_reg;
   reg [1:0] held_col_reg;
   reg [2:0] held_sense_reg;
   reg [25:0] long_cnt_reg;
   reg long_done_reg;
   reg any_next;
   reg [1:0] col_next;
   reg [2:0] sense_next;
   integer c;
   integer s;
   integer r;
   wire scanning = run && scan_en;
   wire unit_tick = (unit_cnt_reg == UNIT_CYCLES - 1);
   wire step_tick = unit_tick && (step_cnt_reg == scan_period);
   wire [4:0] sample = ~sense_s2_reg;
   wire [5:0] base = {1'b0, held_col_reg[1], 4'h0} + (held_col_reg[0] ? 6'h05 : 6'h00);

   // lowest code wins when several keys close together
   always @*
   begin
      any_next = 1'b0;
      col_next = 2'd0;
      sense_next = 3'd0;
      for (c = 3; c >= 0; c = c - 1)
         for (s = 4; s >= 0; s = s - 1)
            if (stable_mem[c][s])
            begin
               any_next = 1'b1;
               col_next = c[1:0];
               sense_next = s[2:0];
            end
   end

   always @(posedge clk)
   begin
      sense_s1_reg <= key_sense_in;
      sense_s2_reg <= sense_s1_reg;
      press_evt <= 1'b0;
      long_evt <= 1'b0;
      if (rst)
      begin
         unit_cnt_reg <= 26'd0;
         step_cnt_reg <= 4'd0;
         col_reg <= 2'd0;
         key_strobe_out <= 4'hf;
         for (r = 0; r < 4; r = r + 1)
         begin
            last_mem[r] <= 5'h00;
            stable_mem[r] <= 5'h00;
         end
         held_reg <= 1'b0;
         held_col_reg <= 2'd0;
         held_sense_reg <= 3'd0;
         long_cnt_reg <= 26'd0;
         long_done_reg <= 1'b0;
         key_code <= 8'h00;
         sense_any <= 1'b0;
      end
      else
      begin
         // strobes idle high when stopped, so a closed key pulls no line
         sense_any <= |sample;
         if (!scanning)
            key_strobe_out <= 4'hf;
         else
         begin
            unit_cnt_reg <= unit_tick ? 26'd0 : unit_cnt_reg + 26'd1;
            if (unit_tick)
               step_cnt_reg <= step_tick ? 4'd0 : step_cnt_reg + 4'd1;
            if (step_tick)
            begin
               // a change must repeat on the next full scan to count
               last_mem[col_reg] <= sample;
               if (sample == last_mem[col_reg])
                  stable_mem[col_reg] <= sample;
               col_reg <= col_reg + 2'd1;
               key_strobe_out <= ~(4'h1 << (col_reg + 2'd1));
            end
            if (!held_reg)
            begin
               if (any_next)
               begin
                  held_reg <= 1'b1;
                  held_col_reg <= col_next;
                  held_sense_reg <= sense_next;
                  long_cnt_reg <= 26'd0;
                  long_done_reg <= 1'b0;
                  key_code <= {1'b1, 1'b0,
                     {1'b0, col_next[1], 4'h0} + (col_next[0] ? 6'h05 : 6'h00)
                     + {3'b000, sense_next}};
                  press_evt <= 1'b1;
               end
            end
            else if (!stable_mem[held_col_reg][held_sense_reg])
            begin
               held_reg <= 1'b0;
               key_code[`BIT_KEY_HELD] <= 1'b0;
            end
            else if (!long_done_reg)
            begin
               if (long_cnt_reg == LONG_CYCLES - 1)
               begin
                  long_done_reg <= 1'b1;
                  key_code <= {2'b10, base + {3'b000, held_sense_reg} + 6'h20};
                  long_evt <= 1'b1;
               end
               else
                  long_cnt_reg <= long_cnt_reg + 26'd1;
            end
         end
      end
   end
endmodule // key_scanner

// *** hdl/lcd_sysctl_keyscan_power.v ***
// What this block does
// - power-a bit 7 high turns the charge-pump booster on, low off.
// - power-a bit 6 high selects internal reference, low external.
// - power-a bit 5 switches the voltage regulator on or off.
// - power-a bit 4 switches the voltage follower on or off.
// - power-a sits at index 11h, written as index then data byte.
// - power-b bits 5..3 pick regulator ratio, 2x to 5x in half steps.
// - power-b at index 12h picks booster clock and driver current.
// - contrast-bias register picks LCD bias from 1/4 to 1/7.
// - panel-on bit low blanks driver, all common and segment lines grounded.
// - interrupts come from RAM write done, scroll shift and key press.
// - each source maskable; pending bits readable in a status register.
// - interrupt output active low until host clears the pending status.
// - scan a 4x5 matrix, four strobes, five senses, register-set period.
// - short codes 00h-04h, 05h-09h, 10h-14h, 15h-19h per strobe.
// - key held over one second interrupts and adds 20h to code.
// - key code shows short press, long press and release apart.
// - eight pins, each input or output, usable to wake the device.
// - two EL driver outputs, active time set by EL register.
// - write-mode bits pick one of three built-in ASCII tables.
// - sleep bit 0 stops display, blanks lines, strobes high, pins held.
// - wake by host writing bit 0 high, key activity or pin.
// - wake restarts oscillator for 250 ms before commands and panel.
`include "lcd_sysctl_map.vh"

module lcd_sysctl_keyscan_power #(
   parameter WAKE_CYCLES = `WAKE_TIME_MS * `CLK_KHZ,
   parameter SECOND_CYCLES = `EL_SECOND_MS * `CLK_KHZ,
   parameter LONG_CYCLES = `LONG_PRESS_MS * `CLK_KHZ,
   parameter SCAN_UNIT_CYCLES = `SCAN_UNIT_MS * `CLK_KHZ
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // host port
   input wire cs_n,
   input wire rs,
   input wire wr_n,
   input wire rd_n,
   input wire [7:0] db_in,
   output reg [7:0] db_out,
   output reg db_oe,
   output reg host_ready,
   output reg int_n,
   // display side events
   input wire ram_write_done,
   input wire scroll_shift,
   // key matrix
   input wire [4:0] key_sense_in,
   output wire [3:0] key_strobe_out,
   // general pins
   input wire [7:0] io_in,
   output reg [7:0] io_out,
   output reg [7:0] io_oe,
   // power and driver controls
   output reg booster_en,
   output reg vref_internal_en,
   output reg regulator_en,
   output reg follower_en,
   output reg [2:0] reg_ratio,
   output reg [1:0] booster_clk_sel,
   output reg [2:0] drive_current,
   output reg [1:0] bias_sel,
   output reg panel_drive_on,
   output reg osc_run,
   output reg [1:0] font_table_select,
   // el driver
   output reg el_charge,
   output reg el_discharge
);
   localparam ST_RUN = 3'b001;
   localparam ST_SLEEP = 3'b010;
   localparam ST_WAKE = 3'b100;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg cs_s1_reg, cs_s2_reg, rs_s1_reg, rs_s2_reg;
   reg wr_s1_reg, wr_s2_reg, wr_d_reg, rd_s1_reg, rd_s2_reg, rd_d_reg;
   reg [7:0] db_s1_reg, db_s2_reg, io_s1_reg, io_s2_reg;
   reg [7:0] index_reg;
   reg [7:0] power_mode_reg;
   reg [7:0] driver_power_enable_a_reg;
   reg [7:0] driver_power_tuning_b_reg;
   reg [7:0] contrast_bias_reg;
   reg [7:0] int_mask_reg;
   reg [2:0] int_status_reg;
   reg [2:0] int_status_next;
   reg [7:0] key_scan_cfg_reg;
   reg [7:0] io_dir_reg;
   reg [7:0] io_out_reg;
   reg [7:0] io_wake_en_reg;
   reg [7:0] el_timing_reg;
   reg [7:0] write_mode_reg;
   reg [23:0] wake_cnt_reg;
   reg [25:0] sec_cnt_reg;
   reg [4:0] el_sec_reg;
   reg [7:0] rd_data;
   wire [7:0] key_code;
   wire key_press_evt;
   wire key_long_evt;
   wire key_sense_any;

   // host strobes are asynchronous pins
   always @(posedge clk)
   begin
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      rs_s1_reg <= rs;
      rs_s2_reg <= rs_s1_reg;
      wr_s1_reg <= wr_n;
      wr_s2_reg <= wr_s1_reg;
      wr_d_reg <= wr_s2_reg;
      rd_s1_reg <= rd_n;
      rd_s2_reg <= rd_s1_reg;
      rd_d_reg <= rd_s2_reg;
      db_s1_reg <= db_in;
      db_s2_reg <= db_s1_reg;
      io_s1_reg <= io_in;
      io_s2_reg <= io_s1_reg;
   end

   // write lands on the trailing edge of the write strobe
   wire wr_end = wr_s2_reg && !wr_d_reg && !cs_s2_reg;
   wire rd_start = !rd_s2_reg && rd_d_reg && !cs_s2_reg;
   wire is_run = (state_reg == ST_RUN);
   wire idx_write = wr_end && !rs_s2_reg && is_run;
   // only the wake command gets through while asleep
   wire wake_cmd = wr_end && rs_s2_reg && state_reg == ST_SLEEP
      && index_reg == `IDX_POWER_MODE && db_s2_reg[`BIT_SLEEP_CTRL];
   wire data_write = wr_end && rs_s2_reg && is_run;
   wire [7:0] io_wake_hits = io_s2_reg & io_wake_en_reg & ~io_dir_reg;
   wire sec_tick = (sec_cnt_reg == SECOND_CYCLES - 1);

   key_scanner #(
      .UNIT_CYCLES(SCAN_UNIT_CYCLES),
      .LONG_CYCLES(LONG_CYCLES)
   ) u_scan (
      .clk(clk),
      .rst(rst),
      .run(is_run),
      .scan_en(key_scan_cfg_reg[`BIT_SCAN_EN]),
      .scan_period(key_scan_cfg_reg[3:0]),
      .key_sense_in(key_sense_in),
      .key_strobe_out(key_strobe_out),
      .key_code(key_code),
      .press_evt(key_press_evt),
      .long_evt(key_long_evt),
      .sense_any(key_sense_any)
   );

   always @*
   begin
      case (state_reg)
         ST_RUN:
            state_next = (data_write && index_reg == `IDX_POWER_MODE
               && !db_s2_reg[`BIT_SLEEP_CTRL]) ? ST_SLEEP : ST_RUN;
         ST_SLEEP:
            state_next = (wake_cmd || key_sense_any || |io_wake_hits)
               ? ST_WAKE : ST_SLEEP;
         ST_WAKE:
            state_next = (wake_cnt_reg == WAKE_CYCLES - 1) ? ST_RUN : ST_WAKE;
         default:
            state_next = ST_RUN;
      endcase
   end

   // a new event beats a clear in the same cycle
   always @*
   begin
      int_status_next = int_status_reg;
      if (data_write && index_reg == `IDX_INT_STATUS)
         int_status_next = int_status_reg & ~db_s2_reg[2:0];
      int_status_next[`BIT_INT_RAM] = int_status_next[`BIT_INT_RAM] | ram_write_done;
      int_status_next[`BIT_INT_SCROLL] = int_status_next[`BIT_INT_SCROLL] | scroll_shift;
      int_status_next[`BIT_INT_KEY] = int_status_next[`BIT_INT_KEY]
         | key_press_evt | key_long_evt;
   end

   always @*
   begin
      case (index_reg)
         `IDX_POWER_MODE: rd_data = power_mode_reg;
         `IDX_DRV_POWER_A: rd_data = driver_power_enable_a_reg;
         `IDX_DRV_POWER_B: rd_data = driver_power_tuning_b_reg;
         `IDX_CONTRAST_BIAS: rd_data = contrast_bias_reg;
         `IDX_INT_MASK: rd_data = int_mask_reg;
         `IDX_INT_STATUS: rd_data = {5'h00, int_status_reg};
         `IDX_KEY_CODE: rd_data = key_code;
         `IDX_KEY_SCAN_CFG: rd_data = key_scan_cfg_reg;
         `IDX_IO_DIR: rd_data = io_dir_reg;
         `IDX_IO_OUT: rd_data = io_out_reg;
         `IDX_IO_IN: rd_data = io_s2_reg;
         `IDX_IO_WAKE_EN: rd_data = io_wake_en_reg;
         `IDX_EL_TIMING: rd_data = el_timing_reg;
         `IDX_WRITE_MODE: rd_data = write_mode_reg;
         default: rd_data = 8'h00;
      endcase
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         state_reg <= ST_RUN;
         index_reg <= 8'h00;
         power_mode_reg <= `RST_POWER_MODE;
         driver_power_enable_a_reg <= `RST_DRV_POWER_A;
         driver_power_tuning_b_reg <= `RST_DRV_POWER_B;
         contrast_bias_reg <= `RST_CONTRAST_BIAS;
         int_mask_reg <= `RST_INT_MASK;
         int_status_reg <= 3'b000;
         key_scan_cfg_reg <= `RST_KEY_SCAN_CFG;
         io_dir_reg <= `RST_IO_DIR;
         io_out_reg <= `RST_IO_OUT;
         io_wake_en_reg <= `RST_IO_WAKE_EN;
         el_timing_reg <= `RST_EL_TIMING;
         write_mode_reg <= `RST_WRITE_MODE;
         wake_cnt_reg <= 24'd0;
         db_out <= 8'h00;
         db_oe <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         int_status_reg <= int_status_next;
         wake_cnt_reg <= (state_reg == ST_WAKE) ? wake_cnt_reg + 24'd1 : 24'd0;
         if (state_reg == ST_SLEEP && state_next == ST_WAKE)
            power_mode_reg[`BIT_SLEEP_CTRL] <= 1'b1;
         if (idx_write)
            index_reg <= db_s2_reg;
         if (rd_start)
            db_out <= rs_s2_reg ? rd_data : index_reg;
         db_oe <= !cs_s2_reg && !rd_s2_reg;
         if (data_write)
         begin
            case (index_reg)
               `IDX_POWER_MODE: power_mode_reg <= db_s2_reg;
               `IDX_DRV_POWER_A: driver_power_enable_a_reg <= db_s2_reg;
               `IDX_DRV_POWER_B: driver_power_tuning_b_reg <= db_s2_reg;
               `IDX_CONTRAST_BIAS: contrast_bias_reg <= db_s2_reg;
               `IDX_INT_MASK: int_mask_reg <= db_s2_reg;
               `IDX_KEY_SCAN_CFG: key_scan_cfg_reg <= db_s2_reg;
               `IDX_IO_DIR: io_dir_reg <= db_s2_reg;
               `IDX_IO_OUT: io_out_reg <= db_s2_reg;
               `IDX_IO_WAKE_EN: io_wake_en_reg <= db_s2_reg;
               `IDX_EL_TIMING: el_timing_reg <= db_s2_reg;
               `IDX_WRITE_MODE: write_mode_reg <= db_s2_reg;
               default: index_reg <= index_reg;
            endcase
         end
      end
   end

   // booster, regulator and follower drop out of sleep together with the panel; the reference select does not
   always @(posedge clk)
   begin
      if (rst)
      begin
         booster_en <= 1'b0;
         vref_internal_en <= 1'b0;
         regulator_en <= 1'b0;
         follower_en <= 1'b0;
         reg_ratio <= 3'd0;
         booster_clk_sel <= 2'd0;
         drive_current <= 3'd0;
         bias_sel <= 2'd0;
         panel_drive_on <= 1'b0;
         osc_run <= 1'b1;
         font_table_select <= 2'd0;
         host_ready <= 1'b1;
         int_n <= 1'b1;
         io_out <= 8'h00;
         io_oe <= 8'h00;
      end
      else
      begin
         booster_en <= is_run && driver_power_enable_a_reg[`BIT_BOOSTER];
         vref_internal_en <= driver_power_enable_a_reg[`BIT_VREF_INT];
         regulator_en <= is_run && driver_power_enable_a_reg[`BIT_REGULATOR];
         follower_en <= is_run && driver_power_enable_a_reg[`BIT_FOLLOWER];
         reg_ratio <= driver_power_tuning_b_reg[`RATIO_MSB:`RATIO_LSB];
         booster_clk_sel <= driver_power_tuning_b_reg[`BCLK_MSB:`BCLK_LSB];
         drive_current <= driver_power_tuning_b_reg[`CURR_MSB:`CURR_LSB];
         bias_sel <= contrast_bias_reg[1:0];
         // low grounds every common and segment line
         panel_drive_on <= is_run && power_mode_reg[`BIT_PANEL_ON];
         osc_run <= (state_next != ST_SLEEP);
         font_table_select <= write_mode_reg[1:0];
         host_ready <= (state_next == ST_RUN);
         int_n <= ~|(int_status_next & int_mask_reg[2:0]);
         // pins keep their last levels through sleep
         if (is_run)
         begin
            io_out <= io_out_reg;
            io_oe <= io_dir_reg;
         end
      end
   end

   // el timing: code 0 is one second, code n is 2n seconds
   always @(posedge clk)
   begin
      if (rst)
      begin
         sec_cnt_reg <= 26'd0;
         el_sec_reg <= 5'd0;
         el_charge <= 1'b0;
         el_discharge <= 1'b0;
      end
      else
      begin
         sec_cnt_reg <= sec_tick ? 26'd0 : sec_cnt_reg + 26'd1;
         if (data_write && index_reg == `IDX_EL_TIMING && db_s2_reg[`BIT_EL_START])
         begin
            el_charge <= 1'b1;
            el_discharge <= 1'b0;
            el_sec_reg <= (db_s2_reg[3:0] == 4'h0) ? 5'd1 : {db_s2_reg[3:0], 1'b0};
            sec_cnt_reg <= 26'd0;
         end
         else if (sec_tick)
         begin
            if (el_charge)
            begin
               if (el_sec_reg == 5'd1)
               begin
                  el_charge <= 1'b0;
                  el_discharge <= 1'b1;
               end
               else
                  el_sec_reg <= el_sec_reg - 5'd1;
            end
            else
               el_discharge <= 1'b0;
         end
      end
   end
endmodule // lcd_sysctl_keyscan_power

// *** hdl/lcd_sysctl_map.vh ***
`ifndef LCD_SYSCTL_MAP_VH
`define LCD_SYSCTL_MAP_VH

// register indices
`define IDX_POWER_MODE 8'h01
`define IDX_CONTRAST_BIAS 8'h02
`define IDX_INT_MASK 8'h03
`define IDX_INT_STATUS 8'h04
`define IDX_KEY_CODE 8'h05
`define IDX_KEY_SCAN_CFG 8'h06
`define IDX_IO_DIR 8'h07
`define IDX_IO_OUT 8'h08
`define IDX_IO_IN 8'h09
`define IDX_IO_WAKE_EN 8'h0a
`define IDX_EL_TIMING 8'h0b
`define IDX_WRITE_MODE 8'h0c
`define IDX_DRV_POWER_A 8'h11
`define IDX_DRV_POWER_B 8'h12

// reset values
`define RST_POWER_MODE 8'h01
`define RST_DRV_POWER_A 8'h00
`define RST_DRV_POWER_B 8'h00
`define RST_CONTRAST_BIAS 8'h00
`define RST_INT_MASK 8'h00
`define RST_KEY_SCAN_CFG 8'h01
`define RST_IO_DIR 8'h00
`define RST_IO_OUT 8'h00
`define RST_IO_WAKE_EN 8'h00
`define RST_EL_TIMING 8'h00
`define RST_WRITE_MODE 8'h00

// field positions
`define BIT_BOOSTER 7
`define BIT_VREF_INT 6
`define BIT_REGULATOR 5
`define BIT_FOLLOWER 4
`define RATIO_MSB 5
`define RATIO_LSB 3
`define BCLK_MSB 7
`define BCLK_LSB 6
`define CURR_MSB 2
`define CURR_LSB 0
`define BIT_SLEEP_CTRL 0
`define BIT_PANEL_ON 1
`define BIT_SCAN_EN 7
`define BIT_EL_START 7
`define BIT_INT_RAM 0
`define BIT_INT_SCROLL 1
`define BIT_INT_KEY 2
`define BIT_KEY_HELD 7
`define BIT_KEY_LONG 5

// timing, clock in kHz
`define CLK_KHZ 50000
`define WAKE_TIME_MS 250
`define LONG_PRESS_MS 1000
`define SCAN_UNIT_MS 1
`define EL_SECOND_MS 1000

`endif

// *** verification/lcd_host_model.sv ***
module lcd_host_model (
   // clock
   input wire logic clk,
   // host bus
   output logic cs_n,
   output logic rs,
   output logic wr_n,
   output logic rd_n,
   output logic [7:0] db_in,
   input wire logic [7:0] db_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      cs_n = 1'b1;
      rs = 1'b0;
      wr_n = 1'b1;
      rd_n = 1'b1;
      db_in = 8'h00;
   end
   // strobes held 4 clocks each side, the device synchronises over 3
   task automatic strobe_write(input logic a, input logic [7:0] d);
      cs_n <= 1'b0;
      rs <= a;
      db_in <= d;
      wr_n <= 1'b0;
      repeat (4) @(posedge clk);
      wr_n <= 1'b1;
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      db_in <= ~d; // released bus shows no stale value
      repeat (2) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      strobe_write(1'b0, idx);
      strobe_write(1'b1, d);
   endtask
   task automatic rd(input logic [7:0] idx, output logic [7:0] d);
      strobe_write(1'b0, idx);
      cs_n <= 1'b0;
      rs <= 1'b1;
      rd_n <= 1'b0;
      repeat (6) @(posedge clk);
      d = db_out;
      rd_n <= 1'b1;
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      @(posedge clk);
   endtask
endmodule // lcd_host_model

// *** verification/lcd_sysctl_checker.sv ***
module lcd_sysctl_checker #(
   parameter WAKE_CYCLES = 50
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host port
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic db_oe,
   input wire logic host_ready,
   input wire logic int_n,
   // keys
   input wire logic [4:0] key_sense_in,
   input wire logic [3:0] key_strobe_out,
   // power and el
   input wire logic booster_en,
   input wire logic regulator_en,
   input wire logic follower_en,
   input wire logic panel_drive_on,
   input wire logic osc_run,
   input wire logic el_charge,
   input wire logic el_discharge
);
   // margin covers synchronisers and sleep entry
   localparam int WAKE_MAX = WAKE_CYCLES + 30;
   int low_cnt;
   always @(posedge clk)
   begin
      if (rst || host_ready)
         low_cnt <= 0;
      else
         low_cnt <= low_cnt + 1;
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   AST_SLEEP_PANEL: assert property (!osc_run [*2] |-> !panel_drive_on)
      else $error("panel driven in sleep");
   AST_SLEEP_STROBE: assert property (!osc_run [*2] |-> key_strobe_out == 4'hf)
      else $error("strobe low in sleep");
   AST_SLEEP_ANALOG: assert property (!host_ready [*2] |->
      !(booster_en || regulator_en || follower_en))
      else $error("analog enable outside run");
   AST_PANEL_WAKE: assert property ($rose(panel_drive_on) |-> host_ready)
      else $error("panel on before wake done");
   AST_WAKE_TIME: assert property ($rose(host_ready) |-> low_cnt >= WAKE_CYCLES)
      else $error("wake too short");
   AST_INT_HOLD: assert property (!int_n && cs_n && $past(cs_n, 5) |=> !int_n)
      else $error("int released without host");
   AST_OE_START: assert property ($rose(db_oe) |-> !cs_n && !rd_n && !$past(rd_n))
      else $error("bus driven without read");
   AST_OE_END: assert property (rd_n [*5] |-> !db_oe)
      else $error("bus driven after read");
   AST_STROBE_ONE: assert property ($countones(~key_strobe_out) <= 1)
      else $error("two strobes low");
   AST_KEY_WAKE: assert property (!osc_run && key_sense_in != 5'h1f |->
      ##[1:WAKE_MAX] osc_run)
      else $error("key did not wake");
   AST_EL_EXCL: assert property (!(el_charge && el_discharge))
      else $error("el outputs both high");
endmodule // lcd_sysctl_checker

bind lcd_sysctl_keyscan_power lcd_sysctl_checker #(.WAKE_CYCLES(WAKE_CYCLES)) chk (.clk, .rst,
   .cs_n, .rd_n, .db_oe, .host_ready, .int_n, .key_sense_in, .key_strobe_out, .booster_en,
   .regulator_en, .follower_en, .panel_drive_on, .osc_run, .el_charge, .el_discharge);

// *** verification/tb_top.sv ***
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WAKE = 50;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ram_write_done = 1'b0;
   logic scroll_shift = 1'b0;
   logic [4:0] key_sense_in = 5'h1f;
   logic [7:0] io_in = 8'h00;
   wire cs_n, rs, wr_n, rd_n;
   wire [7:0] db_in;
   logic [7:0] db_out, io_out, io_oe;
   logic [3:0] key_strobe_out;
   logic [2:0] reg_ratio, drive_current;
   logic [1:0] booster_clk_sel, bias_sel, font_table_select;
   logic db_oe, host_ready, int_n, booster_en, vref_internal_en, regulator_en, follower_en;
   logic panel_drive_on, osc_run, el_charge, el_discharge;
   logic pressed = 1'b0;
   logic wake_key = 1'b0;
   int ks = 0;
   int kn = 0;
   int n_fail = 0;
   int checked = 0;
   int cyc_cnt = 0;
   logic [7:0] ridx [4] = '{8'h11, 8'h01, 8'h06, 8'h20};
   logic [7:0] rexp [4] = '{8'h00, 8'h01, 8'h01, 8'h00};
   int kst [3] = '{0, 2, 3};
   int ksn [3] = '{0, 1, 4};
   logic [7:0] kex [3] = '{8'h00, 8'h11, 8'h19};
   lcd_sysctl_keyscan_power #(
      .WAKE_CYCLES(WAKE),
      .SECOND_CYCLES(20),
      .LONG_CYCLES(200),
      .SCAN_UNIT_CYCLES(4)
   ) DUT (.*);
   lcd_host_model host (.*);
   always #10 clk = ~clk;
   // matrix: the pressed key pulls its sense line only while its strobe is low
   always @(posedge clk)
      key_sense_in <= wake_key ? 5'h1e
         : (pressed && !key_strobe_out[ks]) ? ~(5'h01 << kn) : 5'h1f;
   always @(posedge clk)
   begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000)
      begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      logic [7:0] d;
      int t;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      chk({host_ready, int_n, osc_run, panel_drive_on, key_strobe_out}, 8'hef);
      foreach (ridx[i])
      begin
         host.rd(ridx[i], d);
         chk(d, rexp[i]);
      end
      for (int i = 0; i < 4; i++)
      begin
         host.wr(8'h11, 8'h80 >> i);
         d = {4'h0, booster_en, vref_internal_en, regulator_en, follower_en};
         chk(d, 8'h08 >> i);
      end
      host.wr(8'h12, 8'hea);
      chk({booster_clk_sel, reg_ratio, drive_current}, 8'hea);
      host.wr(8'h02, 8'h03);
      chk({6'h0, bias_sel}, 8'h03);
      host.wr(8'h0c, 8'h02);
      chk({6'h0, font_table_select}, 8'h02);
      host.wr(8'h01, 8'h03);
      chk({7'h0, panel_drive_on}, 8'h01);
      host.wr(8'h01, 8'h01);
      chk({7'h0, panel_drive_on}, 8'h00);
      for (int i = 0; i < 2; i++)
      begin
         ram_write_done <= (i == 0);
         scroll_shift <= (i == 1);
         @(posedge clk);
         ram_write_done <= 1'b0;
         scroll_shift <= 1'b0;
         repeat (3) @(posedge clk);
         chk({7'h0, int_n}, 8'h01);
         host.rd(8'h04, d);
         chk(d, 8'h01 << i);
         host.wr(8'h03, 8'h01 << i);
         chk({7'h0, int_n}, 8'h00);
         host.wr(8'h04, 8'h01 << i);
         chk({7'h0, int_n}, 8'h01);
      end
      host.wr(8'h03, 8'h04);
      host.wr(8'h06, 8'h80);
      for (int i = 0; i < 3; i++)
      begin
         ks <= kst[i];
         kn <= ksn[i];
         pressed <= 1'b1;
         repeat (100) @(posedge clk);
         host.rd(8'h05, d);
         chk(d, 8'h80 | kex[i]);
         chk({7'h0, int_n}, 8'h00);
         host.wr(8'h04, 8'h04);
         repeat (200) @(posedge clk);
         host.rd(8'h05, d);
         chk(d, 8'ha0 | kex[i]);
         chk({7'h0, int_n}, 8'h00);
         host.wr(8'h04, 8'h04);
         pressed <= 1'b0;
         repeat (100) @(posedge clk);
         host.rd(8'h05, d);
         chk(d, 8'h20 | kex[i]);
      end
      // period 3 means one strobe step every four scan units
      host.wr(8'h06, 8'h83);
      for (int i = 0; i < 2; i++)
      begin
         d = {4'h0, key_strobe_out};
         t = 0;
         while ({4'h0, key_strobe_out} === d && t < 40)
         begin
            @(posedge clk);
            t++;
         end
      end
      chk(t[7:0], 8'h10);
      host.wr(8'h07, 8'hf0);
      host.wr(8'h08, 8'ha5);
      io_in <= 8'h3c;
      host.rd(8'h09, d);
      chk(d, 8'h3c);
      chk(io_oe, 8'hf0);
      chk(io_out, 8'ha5);
      host.wr(8'h0b, 8'h81);
      t = 0;
      while (el_charge === 1'b1 && t < 100)
      begin
         @(posedge clk);
         t++;
      end
      chk({7'h0, t inside {[34:40]}}, 8'h01);
      chk({7'h0, el_discharge}, 8'h01);
      host.wr(8'h0a, 8'h01);
      for (int i = 0; i < 3; i++)
      begin
         host.wr(8'h01, 8'h00);
         chk({1'b0, host_ready, osc_run, panel_drive_on, key_strobe_out}, 8'h0f);
         chk(io_out, 8'ha5);
         host.wr(8'h11, 8'hf0);
         if (i == 0)
            host.wr(8'h01, 8'h01);
         wake_key <= (i == 1);
         io_in <= (i == 2) ? 8'h3d : 8'h3c;
         t = 0;
         while (host_ready !== 1'b1 && t < 500)
         begin
            @(posedge clk);
            t++;
         end
         wake_key <= 1'b0;
         io_in <= 8'h3c;
         chk({7'h0, t inside {[WAKE - 10:WAKE + 20]}}, 8'h01);
         host.rd(8'h11, d);
         chk(d, 8'h10);
      end
      give_verdict();
   end
endmodule // tb_top
